// ### hw/tpg_top.v
// two 8-bit gpio ports with bit-zero edge interrupts, axi4-lite register slave
// assumes pins are asynchronous; pad logic resolves level from oe and pull-high
`include "tpg_consts.vh"
`timescale 1ns/1ps
module tpg_top #(
	parameter ADDR_W = 8
) (
	input wire aclk,
	input wire aresetn,
	input wire [ADDR_W-1:0] s_axi_awaddr,
	input wire [2:0] s_axi_awprot,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [ADDR_W-1:0] s_axi_araddr,
	input wire [2:0] s_axi_arprot,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire [7:0] porta_pin_in,
	output wire [7:0] porta_pin_out,
	output wire [7:0] porta_pin_oe,
	output wire [7:0] porta_pullup_en,
	input wire [7:0] portb_pin_in,
	output wire [7:0] portb_pin_out,
	output wire [7:0] portb_pin_oe,
	output wire [7:0] portb_pullup_en,
	output reg [1:0] pin_irq,
	output reg wake_event
);

	// software-visible state
	reg [7:0] porta_data;
	reg [7:0] porta_direction;
	reg [7:0] porta_pullup;
	reg [7:0] portb_data;
	reg [7:0] portb_direction;
	reg [7:0] portb_pullup;
	reg [7:0] porta_input_enable;
	reg [7:0] portb_input_enable;
	reg [3:0] irq_edge_select;
	reg [1:0] irq_enable;
	reg [1:0] irq_flags;

	// bus bookkeeping
	reg aw_held;
	reg w_held;
	reg [5:0] wr_idx;
	reg [7:0] wr_byte;
	reg wr_lane0;
	reg next_aw_held;
	reg next_w_held;
	reg next_rvalid;
	reg do_write;
	reg wr_hit;
	reg rd_hit;
	reg [7:0] rd_val;
	reg [7:0] next_flag_mask;

	// pin side
	wire [15:0] pins_sync;
	wire [7:0] porta_level;
	wire [7:0] portb_level;
	wire [7:0] porta_ie_eff;
	wire [7:0] portb_ie_eff;
	wire [7:0] porta_view;
	wire [7:0] portb_view;
	wire porta_bit0_edge;
	wire portb_bit0_edge;
	reg [15:0] pins_prev;
	wire [15:0] toggled;
	wire [5:0] rd_idx;

	assign porta_pin_out = porta_data;
	assign portb_pin_out = portb_data;

	assign porta_pin_oe = porta_direction;
	assign portb_pin_oe = portb_direction;

	assign porta_pullup_en = porta_pullup;
	assign portb_pullup_en = portb_pullup;

	// pins cross into aclk before anything looks at them
	tpg_sync #(
		.WIDTH(16)
	) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.async_in({portb_pin_in, porta_pin_in}),
		.sync_out(pins_sync)
	);

	assign porta_level = pins_sync[7:0];
	assign portb_level = pins_sync[15:8];

	// reserved port a enables act as always on, whatever was written
	assign porta_ie_eff = porta_input_enable | `TPG_PORTA_IE_RSVD;
	assign portb_ie_eff = portb_input_enable;

	// input pins read level when enabled, else zero; outputs read latch
	assign porta_view = (porta_direction & porta_data) |
		(~porta_direction & porta_ie_eff & porta_level);
	assign portb_view = (portb_direction & portb_data) |
		(~portb_direction & portb_ie_eff & portb_level);

	// port a bit zero enable gates its interrupt edge
	tpg_edge u_edge_porta (
		.aclk(aclk),
		.aresetn(aresetn),
		.level(porta_level[0]),
		.enable(porta_ie_eff[0] & ~porta_direction[0]),
		.edge_sel(irq_edge_select[`TPG_EDGE_PORTA_LSB+1:`TPG_EDGE_PORTA_LSB]),
		.edge_event(porta_bit0_edge)
	);

	// port b bit zero enable gates its interrupt edge
	tpg_edge u_edge_portb (
		.aclk(aclk),
		.aresetn(aresetn),
		.level(portb_level[0]),
		.enable(portb_ie_eff[0] & ~portb_direction[0]),
		.edge_sel(irq_edge_select[`TPG_EDGE_PORTB_LSB+1:`TPG_EDGE_PORTB_LSB]),
		.edge_event(portb_bit0_edge)
	);

	// only enabled input pins may toggle a wake-up
	assign toggled = (pins_sync ^ pins_prev) &
		{portb_ie_eff & ~portb_direction, porta_ie_eff & ~porta_direction};

	// wake pulse is registered; a pin re-enabled mid-level cannot fake a toggle
	// because pins_prev always tracks the synchronised level
	always @(posedge aclk) begin
		if (!aresetn) begin
			pins_prev <= 16'h0000;
			wake_event <= 1'b0;
		end else begin
			pins_prev <= pins_sync;
			wake_event <= |toggled;
		end
	end

	// write channel bookkeeping: address and data taken in either order
	always @* begin
		do_write = aw_held & w_held & ~s_axi_bvalid;
		if (aw_held) begin
			next_aw_held = ~do_write;
		end else begin
			next_aw_held = s_axi_awvalid & s_axi_awready;
		end
		if (w_held) begin
			next_w_held = ~do_write;
		end else begin
			next_w_held = s_axi_wvalid & s_axi_wready;
		end
	end

	// write decode: data lives in byte lane 0, upper lanes ignored
	always @* begin
		wr_hit = 1'b1;
		if (wr_idx == `TPG_IDX_IRQ_ENABLE) begin
			wr_hit = 1'b1;
		end else if (wr_idx == `TPG_IDX_IRQ_REQUEST) begin
			wr_hit = 1'b1;
		end else if (wr_idx == `TPG_IDX_EDGE_SEL) begin
			wr_hit = 1'b1;
		end else if (wr_idx == `TPG_IDX_PORTA_IE) begin
			wr_hit = 1'b1;
		end else if (wr_idx == `TPG_IDX_PORTB_IE) begin
			wr_hit = 1'b1;
		end else if (wr_idx == `TPG_IDX_PORTA_DATA) begin
			wr_hit = 1'b1;
		end else if (wr_idx == `TPG_IDX_PORTA_DIR) begin
			wr_hit = 1'b1;
		end else if (wr_idx == `TPG_IDX_PORTA_PULL) begin
			wr_hit = 1'b1;
		end else if (wr_idx == `TPG_IDX_PORTB_DATA) begin
			wr_hit = 1'b1;
		end else if (wr_idx == `TPG_IDX_PORTB_DIR) begin
			wr_hit = 1'b1;
		end else if (wr_idx == `TPG_IDX_PORTB_PULL) begin
			wr_hit = 1'b1;
		end else begin
			wr_hit = 1'b0;
		end
	end

	// capture address and data; ready is registered so each drops after a take
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			wr_idx <= 6'h00;
			wr_byte <= 8'h00;
			wr_lane0 <= 1'b0;
		end else begin
			aw_held <= next_aw_held;
			w_held <= next_w_held;
			s_axi_awready <= ~next_aw_held;
			s_axi_wready <= ~next_w_held;
			if (s_axi_awvalid & s_axi_awready) begin
				wr_idx <= s_axi_awaddr[7:2];
			end
			if (s_axi_wvalid & s_axi_wready) begin
				wr_byte <= s_axi_wdata[7:0];
				wr_lane0 <= s_axi_wstrb[0];
			end
		end
	end

	// write response follows the committed write
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `TPG_RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_hit ? `TPG_RESP_OKAY : `TPG_RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// configuration registers; a write without lane 0 leaves them alone
	always @(posedge aclk) begin
		if (!aresetn) begin
			porta_data <= `TPG_RST_ZERO8;
			porta_direction <= `TPG_RST_ZERO8;
			porta_pullup <= `TPG_RST_ZERO8;
			portb_data <= `TPG_RST_ZERO8;
			portb_direction <= `TPG_RST_ZERO8;
			portb_pullup <= `TPG_RST_ZERO8;
			porta_input_enable <= `TPG_RST_IE;
			portb_input_enable <= `TPG_RST_IE;
			irq_edge_select <= `TPG_RST_EDGE;
			irq_enable <= `TPG_RST_FLAGS;
		end else if (do_write & wr_lane0) begin
			if (wr_idx == `TPG_IDX_PORTA_DATA) begin
				porta_data <= wr_byte;
			end else if (wr_idx == `TPG_IDX_PORTA_DIR) begin
				porta_direction <= wr_byte;
			end else if (wr_idx == `TPG_IDX_PORTA_PULL) begin
				porta_pullup <= wr_byte;
			end else if (wr_idx == `TPG_IDX_PORTB_DATA) begin
				portb_data <= wr_byte;
			end else if (wr_idx == `TPG_IDX_PORTB_DIR) begin
				portb_direction <= wr_byte;
			end else if (wr_idx == `TPG_IDX_PORTB_PULL) begin
				portb_pullup <= wr_byte;
			end else if (wr_idx == `TPG_IDX_PORTA_IE) begin
				porta_input_enable <= wr_byte;
			end else if (wr_idx == `TPG_IDX_PORTB_IE) begin
				portb_input_enable <= wr_byte;
			// edge select, timer bit not kept here
			end else if (wr_idx == `TPG_IDX_EDGE_SEL) begin
				irq_edge_select <= wr_byte[3:0];
			end else if (wr_idx == `TPG_IDX_IRQ_ENABLE) begin
				irq_enable <= wr_byte[1:0];
			end
		end
	end

	// writing zero to a flag clears it; ones leave it as it is
	always @* begin
		next_flag_mask = 8'hff;
		if (do_write & wr_lane0 & (wr_idx == `TPG_IDX_IRQ_REQUEST)) begin
			next_flag_mask = wr_byte;
		end
	end

	// set by edge, cleared only by software; the set wins a tie
	always @(posedge aclk) begin
		if (!aresetn) begin
			irq_flags <= `TPG_RST_FLAGS;
		end else begin
			irq_flags <= (irq_flags & next_flag_mask[1:0]) | {portb_bit0_edge, porta_bit0_edge};
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			pin_irq <= 2'h0;
		end else begin
			pin_irq <= irq_flags & irq_enable;
		end
	end

	assign rd_idx = s_axi_araddr[7:2];

	// read mux; write-only registers answer zero with okay
	always @* begin
		rd_hit = 1'b1;
		rd_val = 8'h00;
		if (rd_idx == `TPG_IDX_PORTA_DATA) begin
			rd_val = porta_view;
		end else if (rd_idx == `TPG_IDX_PORTA_DIR) begin
			rd_val = porta_direction;
		end else if (rd_idx == `TPG_IDX_PORTA_PULL) begin
			rd_val = porta_pullup;
		end else if (rd_idx == `TPG_IDX_PORTB_DATA) begin
			rd_val = portb_view;
		end else if (rd_idx == `TPG_IDX_PORTB_DIR) begin
			rd_val = portb_direction;
		end else if (rd_idx == `TPG_IDX_PORTB_PULL) begin
			rd_val = portb_pullup;
		end else if (rd_idx == `TPG_IDX_IRQ_ENABLE) begin
			rd_val = {6'h00, irq_enable};
		end else if (rd_idx == `TPG_IDX_IRQ_REQUEST) begin
			rd_val = {6'h00, irq_flags};
		end else if (rd_idx == `TPG_IDX_EDGE_SEL) begin
			rd_val = 8'h00;
		end else if (rd_idx == `TPG_IDX_PORTA_IE) begin
			rd_val = 8'h00;
		end else if (rd_idx == `TPG_IDX_PORTB_IE) begin
			rd_val = 8'h00;
		end else begin
			rd_hit = 1'b0;
		end
	end

	// one read in flight; arready stays low until the data is taken
	always @* begin
		if (s_axi_rvalid) begin
			next_rvalid = ~s_axi_rready;
		end else begin
			next_rvalid = s_axi_arvalid & s_axi_arready;
		end
	end

	// read data is sampled at the address handshake, not at the data handshake
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `TPG_RESP_OKAY;
		end else begin
			s_axi_arready <= ~next_rvalid;
			s_axi_rvalid <= next_rvalid;
			if (s_axi_arvalid & s_axi_arready) begin
				s_axi_rdata <= {24'h00_0000, rd_val};
				s_axi_rresp <= rd_hit ? `TPG_RESP_OKAY : `TPG_RESP_SLVERR;
			end
		end
	end

endmodule // tpg_top

// ### hw/tpg_consts.vh
// constants for the two-port gpio block: register indices, reset values, field codes
// assumes a 32-bit axi4-lite slave; byte address is four times a register index
//
// Contract
// - port a data register, eight bits, read/write, resets to zero, drives output pins.
// - port a direction bit per pin, resets zero; zero input, one output.
// - port a pull-high enable per pin, resets zero; one turns pull-high on.
// - port b data register, eight bits, read/write, resets to zero, drives output pins.
// - port b direction bit per pin, resets zero; zero input, one output.
// - port b pull-high enable per pin, resets zero; one turns pull-high on.
// - port a top two input enables, write-only, reset ones; cleared blocks wake-up.
// - port a pins five to three input enables, write-only, reset ones, gate wake-up.
// - port a bit zero enable gates digital input, wake-up and pin interrupt.
// - port b pins seven to one input enables, write-only, reset ones, gate wake-up.
// - two-bit edge select per bit-zero source: both, rising, falling, reserved.
// - selected edge sets the source request flag; only software clears it.
// - request reaches the processor only while its enable bit is one.
`ifndef TPG_CONSTS_VH
`define TPG_CONSTS_VH

// register indices
`define TPG_IDX_IRQ_ENABLE 6'h04
`define TPG_IDX_IRQ_REQUEST 6'h05
`define TPG_IDX_EDGE_SEL 6'h0c
`define TPG_IDX_PORTA_IE 6'h0d
`define TPG_IDX_PORTB_IE 6'h0e
`define TPG_IDX_PORTA_DATA 6'h10
`define TPG_IDX_PORTA_DIR 6'h11
`define TPG_IDX_PORTA_PULL 6'h12
`define TPG_IDX_PORTB_DATA 6'h14
`define TPG_IDX_PORTB_DIR 6'h15
`define TPG_IDX_PORTB_PULL 6'h16

// reset values
`define TPG_RST_ZERO8 8'h00
`define TPG_RST_IE 8'hff
`define TPG_RST_EDGE 4'h0
`define TPG_RST_FLAGS 2'h0

// edge select codes and field positions
`define TPG_EDGE_BOTH 2'h0
`define TPG_EDGE_RISE 2'h1
`define TPG_EDGE_FALL 2'h2
`define TPG_EDGE_PORTA_LSB 0
`define TPG_EDGE_PORTB_LSB 2

// port a reserved enable bits, forced on inside the block
`define TPG_PORTA_IE_RSVD 8'h06

// axi responses
`define TPG_RESP_OKAY 2'h0
`define TPG_RESP_SLVERR 2'h2

`endif

// ### hw/tpg_sync.v
// two-flop synchroniser for a bus of independent pin levels
// assumes each bit is a slow level; no bus coherence is promised
`timescale 1ns/1ps
module tpg_sync #(
	parameter WIDTH = 16
) (
	input wire aclk,
	input wire aresetn,
	input wire [WIDTH-1:0] async_in,
	output reg [WIDTH-1:0] sync_out
);

	reg [WIDTH-1:0] stage1;

	// first stage feeds only the second stage
	always @(posedge aclk) begin
		if (!aresetn) begin
			stage1 <= {WIDTH{1'b0}};
			sync_out <= {WIDTH{1'b0}};
		end else begin
			stage1 <= async_in;
			sync_out <= stage1;
		end
	end

endmodule // tpg_sync

// ### hw/tpg_edge.v
// edge detector for one interrupt-capable pin
// assumes level is already synchronised to aclk
`include "tpg_consts.vh"
`timescale 1ns/1ps
module tpg_edge (
	input wire aclk,
	input wire aresetn,
	input wire level,
	input wire enable,
	input wire [1:0] edge_sel,
	output reg edge_event
);

	reg prev_level;
	reg prev_enable;
	reg next_event;

	always @* begin
		next_event = 1'b0;
		case (edge_sel)
			`TPG_EDGE_BOTH: next_event = level ^ prev_level;
			`TPG_EDGE_RISE: next_event = level & ~prev_level;
			`TPG_EDGE_FALL: next_event = ~level & prev_level;
			default: next_event = 1'b0;
		endcase
	end

	// no edge unless enabled both sides of the change
	always @(posedge aclk) begin
		if (!aresetn) begin
			prev_level <= 1'b0;
			prev_enable <= 1'b0;
			edge_event <= 1'b0;
		end else begin
			prev_level <= level;
			prev_enable <= enable;
			edge_event <= next_event & enable & prev_enable;
		end
	end

endmodule // tpg_edge

// ### verification/tpg_pins.sv
// pad model for one 8-bit port: design drive, far-side drive, pull-high
// assumes the bench steers ext_val and ext_en just after aclk edges
`timescale 1ns/1ps
module tpg_pins (
	input wire aclk,
	input wire [7:0] out,
	input wire [7:0] oe,
	input wire [7:0] pull,
	input wire [7:0] ext_val,
	input wire [7:0] ext_en,
	output logic [7:0] level
);
	logic [7:0] last = 8'h00;
	logic [7:0] held;
	// pull when undriven
	// a floating pad shows the inverse of its last driven level, never a tidy copy
	assign held = oe | ext_en | pull;
	assign level = (oe & out) | (~oe & ext_en & ext_val) | (~oe & ~ext_en & (pull | ~last));
	// remember driven and pulled levels only
	always @(posedge aclk) begin
		last <= (held & level) | (~held & last);
	end
endmodule // tpg_pins

// ### verification/tpg_props.sv
// checker on the gpio block ports: pads, irq line and wake tied to causes
// assumes it is bound into tpg_top and sees only its ports
`timescale 1ns/1ps
module tpg_props (
	input wire aclk,
	input wire aresetn,
	input wire s_axi_bvalid,
	input wire s_axi_rvalid,
	input wire [31:0] s_axi_rdata,
	input wire [7:0] porta_pin_in,
	input wire [7:0] portb_pin_in,
	input wire [7:0] porta_pin_out,
	input wire [7:0] portb_pin_out,
	input wire [7:0] porta_pin_oe,
	input wire [7:0] portb_pin_oe,
	input wire [7:0] porta_pullup_en,
	input wire [7:0] portb_pullup_en,
	input wire [1:0] pin_irq,
	input wire wake_event
);
	default clocking dc @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	reg [15:0] prev;
	reg [2:0] quiet;
	// cycles since a pin moved; reset counts as a move since the synchronisers restart
	always @(posedge aclk) begin
		prev <= {porta_pin_in, portb_pin_in};
		if (!aresetn || prev != {porta_pin_in, portb_pin_in}) begin
			quiet <= 3'h0;
		end else if (quiet != 3'h7) begin
			quiet <= quiet + 3'h1;
		end
	end
	sequence commit;
		$rose(s_axi_bvalid);
	endsequence
	sequence irq_up;
		$rose(pin_irq[0]) || $rose(pin_irq[1]);
	endsequence
	rst_outs_a: assert property (
		$rose(aresetn) |-> {porta_pin_out, porta_pin_oe, porta_pullup_en, portb_pin_out,
		portb_pin_oe, portb_pullup_en, pin_irq, wake_event} == 51'h0)
		else $error("pads not clear after reset");
	data_hold_a: assert property (
		$changed({porta_pin_out, portb_pin_out}) |-> commit)
		else $error("pad data moved without a write");
	dir_hold_a: assert property (
		$changed({porta_pin_oe, portb_pin_oe}) |-> commit)
		else $error("pad direction moved without a write");
	pull_hold_a: assert property (
		$changed({porta_pullup_en, portb_pullup_en}) |-> commit)
		else $error("pull-high moved without a write");
	wake_cause_a: assert property (
		wake_event |-> quiet <= 3'h5)
		else $error("wake without a pin change");
	irq_rise_a: assert property (
		irq_up |-> quiet <= 3'h6 || $past(s_axi_bvalid))
		else $error("irq line rose without cause");
	irq_fall_a: assert property (
		$fell(pin_irq[0]) || $fell(pin_irq[1]) |-> $past(s_axi_bvalid))
		else $error("irq line fell without a write");
	rdata_top_a: assert property (
		s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
		else $error("read data upper bits set");
endmodule // tpg_props

// ### verification/tb.sv
// self-checking bench for the two-port gpio block over axi4-lite
// assumes tpg_top, tpg_pins and tpg_props are compiled; checker bound at the foot
`timescale 1ns/1ps
`include "tpg_consts.vh"
module tb;
	localparam logic [5:0] rq = `TPG_IDX_IRQ_REQUEST;
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic [7:0] s_axi_awaddr = 8'h00;
	logic [7:0] s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0000_0000;
	logic s_axi_awvalid = 1'h0;
	logic s_axi_wvalid = 1'h0;
	logic s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0;
	logic s_axi_rready = 1'h0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic [7:0] ext_a = 8'h00;
	logic [7:0] ext_b = 8'h00;
	logic [7:0] en_a = 8'hff;
	logic [7:0] en_b = 8'hff;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, wake_event;
	wire [1:0] s_axi_bresp, s_axi_rresp, pin_irq;
	wire [31:0] s_axi_rdata;
	wire [7:0] porta_pin_in, porta_pin_out, porta_pin_oe, porta_pullup_en;
	wire [7:0] portb_pin_in, portb_pin_out, portb_pin_oe, portb_pullup_en;
	int n_mismatch = 0;
	int tests_run = 0;
	int n_wake = 0;
	int i, c, s, w0;
	logic [3:0] hs;
	logic [5:0] ix;
	logic [7:0] e;
	logic [31:0] v;
	logic [1:0] rs;
	// port a bits 2:1 have no enable of their own, so the blocked step leaves them still
	logic [31:0] wt [4] = '{32'h0000_f9ff, 32'hc000_3fff, 32'h3800_07ff, 32'h0002_07fd};
	// 200 MHz clock
	always #2.5 aclk = ~aclk;
	tpg_top DUT (
		.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.porta_pin_in, .porta_pin_out, .porta_pin_oe, .porta_pullup_en, .portb_pin_in,
		.portb_pin_out, .portb_pin_oe, .portb_pullup_en, .pin_irq, .wake_event
	);
	tpg_pins pads_a (.aclk, .out(porta_pin_out), .oe(porta_pin_oe), .pull(porta_pullup_en),
		.ext_val(ext_a), .ext_en(en_a), .level(porta_pin_in));
	tpg_pins pads_b (.aclk, .out(portb_pin_out), .oe(portb_pin_oe), .pull(portb_pullup_en),
		.ext_val(ext_b), .ext_en(en_b), .level(portb_pin_in));
	// wake pulses counted so a scenario compares before and after
	always @(posedge aclk) begin
		if (wake_event === 1'h1) begin
			n_wake++;
		end
	end
	task chk(input string nm, input logic [33:0] got, input logic [33:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task close_out;
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// one write (w high) or read; payload held until its own ready is seen
	task bus(input logic w, input logic [5:0] a, input logic [7:0] d);
		int k;
		@(posedge aclk);
		if (w) begin
			s_axi_awaddr <= {a, 2'h0};
			s_axi_wdata <= {24'h00_0000, d};
			s_axi_awvalid <= 1'h1;
			s_axi_wvalid <= 1'h1;
			s_axi_bready <= 1'h1;
		end else begin
			s_axi_araddr <= {a, 2'h0};
			s_axi_arvalid <= 1'h1;
			s_axi_rready <= 1'h1;
		end
		for (k = 0; k < 40; k++) begin
			@(negedge aclk);
			hs = {s_axi_awvalid & s_axi_awready, s_axi_wvalid & s_axi_wready,
				s_axi_arvalid & s_axi_arready, s_axi_bvalid | s_axi_rvalid};
			v = s_axi_rdata;
			rs = w ? s_axi_bresp : s_axi_rresp;
			@(posedge aclk);
			if (hs[3]) s_axi_awvalid <= 1'h0;
			if (hs[2]) s_axi_wvalid <= 1'h0;
			if (hs[1]) s_axi_arvalid <= 1'h0;
			if (hs[0]) begin
				s_axi_bready <= 1'h0;
				s_axi_rready <= 1'h0;
				break;
			end
		end
		if (k == 40) begin
			n_mismatch++;
			close_out;
		end
	endtask
	task rc(input logic [5:0] a, input logic [7:0] x);
		bus(1'h0, a, 8'h00);
		chk("read", {rs, v}, {`TPG_RESP_OKAY, 24'h00_0000, x});
	endtask
	// far-side levels, then time for sync, edge and flag stages
	task pins(input logic [7:0] a, input logic [7:0] b);
		ext_a <= a;
		ext_b <= b;
		repeat (8) @(posedge aclk);
	endtask
	initial begin
		repeat (3) @(posedge aclk);
		aresetn <= 1'h1;
		for (i = 0; i < 7; i++) begin
			if (i != 3) rc(`TPG_IDX_PORTA_DATA + 6'(i), 8'h00);
		end
		rc(`TPG_IDX_EDGE_SEL, 8'h00);
		// reset edge code takes both edges; reset enables keep the line low
		pins(8'h01, 8'h01);
		rc(rq, 8'h03);
		chk("irq line", pin_irq, 8'h00);
		bus(1'h1, rq, 8'h00);
		pins(8'h00, 8'h00);
		rc(rq, 8'h03);
		bus(1'h1, rq, 8'h00);
		ext_a <= 8'hb0;
		ext_b <= 8'hb0;
		bus(1'h1, `TPG_IDX_IRQ_ENABLE, 8'h03);
		en_a <= 8'hcf;
		en_b <= 8'hcf;
		// mixed pads: outputs from data, inputs from pins, pulled pins high
		for (i = 0; i < 2; i++) begin
			ix = `TPG_IDX_PORTA_DATA + 6'(4 * i);
			bus(1'h1, ix + 6'h1, 8'h0f);
			bus(1'h1, ix, 8'ha5);
			bus(1'h1, ix + 6'h2, 8'h30);
			chk("pad out", i ? portb_pin_out : porta_pin_out, 8'ha5);
			chk("pad oe", i ? portb_pin_oe : porta_pin_oe, 8'h0f);
			chk("pull", i ? portb_pullup_en : porta_pullup_en, 8'h30);
			rc(ix, 8'hb5);
			rc(ix + 6'h1, 8'h0f);
			rc(ix + 6'h2, 8'h30);
			bus(1'h1, ix + 6'h1, 8'h00);
			bus(1'h1, ix + 6'h2, 8'h00);
		end
		en_a <= 8'hff;
		en_b <= 8'hff;
		pins(8'h00, 8'h00);
		bus(1'h1, 6'h3f, 8'h11);
		chk("bresp", rs, `TPG_RESP_SLVERR);
		chk("pad out", porta_pin_out, 8'ha5);
		// a write without byte lane 0 is answered okay and changes nothing
		s_axi_wstrb <= 4'he;
		bus(1'h1, `TPG_IDX_PORTA_DATA, 8'h11);
		s_axi_wstrb <= 4'hf;
		chk("lane", {rs, porta_pin_out}, {`TPG_RESP_OKAY, 8'ha5});
		bus(1'h0, 6'h3f, 8'h00);
		chk("rresp", {rs, v}, {`TPG_RESP_SLVERR, 32'h0000_0000});
		// only the three defined edge codes
		for (c = 0; c < 3; c++) begin
			bus(1'h1, `TPG_IDX_EDGE_SEL, {4'h0, 2'(c), 2'(c)});
			for (s = 0; s < 2; s++) begin
				bus(1'h1, rq, 8'h00);
				pins({7'h00, ~s[0]}, {7'h00, ~s[0]});
				e = (c == 2 - s) ? 8'h00 : 8'h03;
				rc(rq, e);
				chk("irq line", pin_irq, e);
			end
		end
		// masked source keeps its flag off the line
		bus(1'h1, `TPG_IDX_IRQ_ENABLE, 8'h01);
		bus(1'h1, `TPG_IDX_EDGE_SEL, 8'h00);
		bus(1'h1, rq, 8'h00);
		pins(8'h01, 8'h01);
		rc(rq, 8'h03);
		chk("irq line", pin_irq, 8'h01);
		bus(1'h1, rq, 8'h00);
		rc(rq, 8'h00);
		chk("irq line", pin_irq, 8'h00);
		// bit-zero enables written as zero, port a reserved bits with them
		bus(1'h1, `TPG_IDX_PORTA_IE, 8'hf8);
		bus(1'h1, `TPG_IDX_PORTB_IE, 8'hfe);
		rc(`TPG_IDX_PORTA_DATA, 8'h00);
		rc(`TPG_IDX_PORTB_DATA, 8'h00);
		bus(1'h1, rq, 8'h00);
		pins(8'h00, 8'h00);
		rc(rq, 8'h00);
		// wake gating per enable group: all cleared, then port a top two, port a pins five to three, port b pin one
		for (i = 0; i < 4; i++) begin
			bus(1'h1, `TPG_IDX_PORTA_IE, wt[i][31:24]);
			bus(1'h1, `TPG_IDX_PORTB_IE, wt[i][23:16]);
			pins(ext_a, ext_b);
			w0 = n_wake;
			pins(wt[i][15:8], wt[i][7:0]);
			chk("wake", 34'(n_wake - w0), 34'(i != 0));
		end
		close_out;
	end
endmodule // tb
bind tpg_top tpg_props props (.aclk, .aresetn, .s_axi_bvalid, .s_axi_rvalid, .s_axi_rdata,
	.porta_pin_in, .portb_pin_in, .porta_pin_out, .portb_pin_out, .porta_pin_oe,
	.portb_pin_oe, .porta_pullup_en, .portb_pullup_en, .pin_irq, .wake_event);
